//--- rtl/nfcs_pkg.sv
package nfcs_pkg;
  // unlock addresses and command codes
  localparam logic [18:0] NFCS_ADDR_UNLOCK1 = 19'h00555;
  localparam logic [18:0] NFCS_ADDR_UNLOCK2 = 19'h002AA;
  localparam logic [18:0] NFCS_ADDR_QUERY = 19'h000AA;
  localparam logic [18:0] NFCS_ADDR_ANY = 19'h00000;
  localparam logic [7:0] NFCS_CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] NFCS_CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] NFCS_CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] NFCS_CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] NFCS_CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] NFCS_CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] NFCS_CMD_AUTOSELECT = 8'h90;
  localparam logic [7:0] NFCS_CMD_RESET = 8'hF0;
  localparam logic [7:0] NFCS_CMD_QUERY = 8'h98;
  localparam logic [7:0] NFCS_CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] NFCS_CMD_RESUME = 8'h30;
  // operation codes written by software
  localparam logic [3:0] NFCS_OP_PROGRAM = 4'h1;
  localparam logic [3:0] NFCS_OP_CHIP_ERASE = 4'h2;
  localparam logic [3:0] NFCS_OP_SECTOR_ERASE = 4'h3;
  localparam logic [3:0] NFCS_OP_AUTOSELECT = 4'h4;
  localparam logic [3:0] NFCS_OP_QUERY = 4'h5;
  localparam logic [3:0] NFCS_OP_RESET = 4'h6;
  localparam logic [3:0] NFCS_OP_SUSPEND = 4'h7;
  localparam logic [3:0] NFCS_OP_RESUME = 4'h8;
  localparam logic [3:0] NFCS_OP_READ = 4'h9;
  localparam logic [3:0] NFCS_OP_ADD_SECTOR = 4'hA;
  // apb register offsets
  localparam logic [11:0] NFCS_REG_CTRL = 12'h000;
  localparam logic [11:0] NFCS_REG_ADDR = 12'h004;
  localparam logic [11:0] NFCS_REG_WDATA = 12'h008;
  localparam logic [11:0] NFCS_REG_STATUS = 12'h00C;
  localparam logic [11:0] NFCS_REG_RDATA = 12'h010;
  // status byte bit positions
  localparam int NFCS_BIT_POLL = 7;
  localparam int NFCS_BIT_TOGGLE = 6;
  localparam int NFCS_BIT_FAIL = 5;
  localparam int NFCS_BIT_WINDOW = 3;
  localparam int NFCS_BIT_SECT = 2;
  // bus cycle timing, in 40 ns clock cycles per phase
  localparam int NFCS_CLK_NS = 40;
  localparam int NFCS_PHASE_NS = 80;
  localparam logic [3:0] NFCS_PHASE_CYC =
    4'((NFCS_PHASE_NS + NFCS_CLK_NS - 1) / NFCS_CLK_NS);
  localparam logic [2:0] NFCS_SEQ_MAX = 3'd6;
endpackage : nfcs_pkg

//--- rtl/nfcs_bus_cycle.sv
`timescale 1ns/1ps
// one flash bus write or read cycle on the asynchronous pins
module nfcs_bus_cycle
  import nfcs_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic [18:0] fl_addr_o,
  output logic fl_ce_n_o,
  output logic fl_we_n_o,
  output logic fl_oe_n_o,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe_o,
  input wire logic [7:0] fl_dq_i
);
  typedef enum logic [1:0] {NFCS_BC_IDLE, NFCS_BC_SETUP, NFCS_BC_STROBE, NFCS_BC_HOLD} nfcs_bc_t;
  nfcs_bc_t state_q;
  logic [3:0] cnt_q;
  logic wr_q;

  // phase sequencer; ce and we fall together and rise together
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= NFCS_BC_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      case (state_q)
        NFCS_BC_IDLE: begin
          if (start_i) begin
            state_q <= NFCS_BC_SETUP;
            wr_q <= write_i;
            cnt_q <= NFCS_PHASE_CYC;
          end
        end
        NFCS_BC_SETUP: begin
          state_q <= NFCS_BC_STROBE;
          cnt_q <= NFCS_PHASE_CYC;
        end
        NFCS_BC_STROBE: begin
          if (cnt_q <= 4'h1) begin
            state_q <= NFCS_BC_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        NFCS_BC_HOLD: begin
          state_q <= NFCS_BC_IDLE;
          done_o <= 1'b1;
        end
        default: state_q <= NFCS_BC_IDLE;
      endcase
    end
  end

  // strobes together, data held past rise
  // pin drive; oe stays high during writes so the cycle counts as a write
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      fl_addr_o <= 19'h00000;
      fl_dq_o <= 8'h00;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o <= 1'b1;
      fl_we_n_o <= 1'b1;
      fl_oe_n_o <= 1'b1;
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (state_q == NFCS_BC_IDLE && start_i) begin
        fl_addr_o <= addr_i;
        fl_dq_o <= data_i;
        fl_dq_oe_o <= write_i;
      end
      fl_ce_n_o <= !(state_q == NFCS_BC_SETUP || state_q == NFCS_BC_STROBE);
      fl_we_n_o <= !(wr_q && (state_q == NFCS_BC_SETUP || state_q == NFCS_BC_STROBE));
      fl_oe_n_o <= !(!wr_q && (state_q == NFCS_BC_SETUP || state_q == NFCS_BC_STROBE));
      if (state_q == NFCS_BC_STROBE && cnt_q <= 4'h1 && !wr_q) begin
        rdata_o <= fl_dq_i;
      end
      // release data one cycle after the strobes rise, so it never moves under them
      if (state_q == NFCS_BC_IDLE && !start_i) begin
        fl_dq_oe_o <= 1'b0;
      end
    end
  end

  assign busy_o = (state_q != NFCS_BC_IDLE);
endmodule : nfcs_bus_cycle

//--- rtl/nfcs_top.sv
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - program: AA 555, 55 2AA, A0 555, data
// - chip erase: unlock, 80, unlock, 10
// - sector erase: sixth write 30 at sector
// - only defined command codes are issued
// - after failure host must issue reset
// - autoselect and query left by reset
// - device latches address and data on strobes
module nfcs_top
  import nfcs_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [18:0] fl_addr_o,
  output logic fl_ce_n_o,
  output logic fl_we_n_o,
  output logic fl_oe_n_o,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe_o,
  input wire logic [7:0] fl_dq_i
);
  typedef enum logic [1:0] {NFCS_IDLE, NFCS_ISSUE, NFCS_WAIT} nfcs_state_t;
  nfcs_state_t state_q;
  logic [3:0] op_q;
  logic [18:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] prev_q;
  logic toggled_q;
  logic [2:0] step_q;
  logic [2:0] len_q;
  logic bc_start;
  logic bc_write;
  logic [18:0] bc_addr;
  logic [7:0] bc_data;
  logic bc_busy;
  logic bc_done;
  logic [7:0] bc_rdata;
  logic apb_wr;
  logic apb_rd;
  logic go;

  // fixed sequences per operation, one entry per write step
  function automatic logic [26:0] nfcs_step(input logic [3:0] op, input logic [2:0] step,
                                            input logic [18:0] a, input logic [7:0] d);
    logic [26:0] r;
    r = {NFCS_ADDR_ANY, NFCS_CMD_RESET};
    case (op)
      NFCS_OP_RESET: r = {NFCS_ADDR_ANY, NFCS_CMD_RESET};
      NFCS_OP_QUERY: r = {NFCS_ADDR_QUERY, NFCS_CMD_QUERY};
      NFCS_OP_SUSPEND: r = {NFCS_ADDR_ANY, NFCS_CMD_SUSPEND};
      NFCS_OP_RESUME: r = {NFCS_ADDR_ANY, NFCS_CMD_RESUME};
      NFCS_OP_ADD_SECTOR: r = {a, NFCS_CMD_SECTOR_ERASE};
      default: begin
        case (step)
          3'd0: r = {NFCS_ADDR_UNLOCK1, NFCS_CMD_UNLOCK1};
          3'd1: r = {NFCS_ADDR_UNLOCK2, NFCS_CMD_UNLOCK2};
          3'd2: r = {NFCS_ADDR_UNLOCK1, (op == NFCS_OP_PROGRAM) ? NFCS_CMD_PROGRAM :
                     (op == NFCS_OP_AUTOSELECT) ? NFCS_CMD_AUTOSELECT : NFCS_CMD_ERASE_SETUP};
          3'd3: r = (op == NFCS_OP_PROGRAM) ? {a, d} : {NFCS_ADDR_UNLOCK1, NFCS_CMD_UNLOCK1};
          3'd4: r = {NFCS_ADDR_UNLOCK2, NFCS_CMD_UNLOCK2};
          default: r = (op == NFCS_OP_CHIP_ERASE) ? {NFCS_ADDR_UNLOCK1, NFCS_CMD_CHIP_ERASE} :
                       {a, NFCS_CMD_SECTOR_ERASE};
        endcase
      end
    endcase
    return r;
  endfunction : nfcs_step

  // number of bus cycles in each sequence; read is a single read cycle
  function automatic logic [2:0] nfcs_len(input logic [3:0] op);
    case (op)
      NFCS_OP_PROGRAM: return 3'd4;
      NFCS_OP_CHIP_ERASE: return NFCS_SEQ_MAX;
      NFCS_OP_SECTOR_ERASE: return NFCS_SEQ_MAX;
      NFCS_OP_AUTOSELECT: return 3'd3;
      NFCS_OP_READ: return 3'd1;
      default: return 3'd1;
    endcase
  endfunction : nfcs_len

  function automatic logic nfcs_valid(input logic [3:0] op);
    return (op >= NFCS_OP_PROGRAM) && (op <= NFCS_OP_ADD_SECTOR);
  endfunction : nfcs_valid

  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign go = clk_en_i && apb_wr && paddr_i == NFCS_REG_CTRL && state_q == NFCS_IDLE &&
              nfcs_valid(pwdata_i[3:0]);

  // address and data registers
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      addr_q <= 19'h00000;
      wdata_q <= 8'h00;
    end else if (clk_en_i && apb_wr) begin
      if (paddr_i == NFCS_REG_ADDR) begin
        addr_q <= pwdata_i[18:0];
      end
      if (paddr_i == NFCS_REG_WDATA) begin
        wdata_q <= pwdata_i[7:0];
      end
    end
  end

  // sequence engine
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= NFCS_IDLE;
      op_q <= 4'h0;
      step_q <= 3'd0;
      len_q <= 3'd1;
    end else if (clk_en_i) begin
      case (state_q)
        NFCS_IDLE: begin
          if (go) begin
            op_q <= pwdata_i[3:0];
            len_q <= nfcs_len(pwdata_i[3:0]);
            step_q <= 3'd0;
            state_q <= NFCS_ISSUE;
          end
        end
        NFCS_ISSUE: begin
          if (!bc_busy) begin
            state_q <= NFCS_WAIT;
          end
        end
        NFCS_WAIT: begin
          if (bc_done) begin
            if (step_q + 3'd1 >= len_q) begin
              state_q <= NFCS_IDLE;
            end else begin
              step_q <= step_q + 3'd1;
              state_q <= NFCS_ISSUE;
            end
          end
        end
        default: state_q <= NFCS_IDLE;
      endcase
    end
  end

  assign bc_start = (state_q == NFCS_ISSUE) && !bc_busy;
  assign bc_write = (op_q != NFCS_OP_READ);
  assign {bc_addr, bc_data} = (op_q == NFCS_OP_READ) ? {addr_q, 8'h00} :
                              nfcs_step(op_q, step_q, addr_q, wdata_q);

  // read capture; toggle flag compares bit 6 of consecutive reads
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
      prev_q <= 8'h00;
      toggled_q <= 1'b0;
    end else if (clk_en_i && bc_done && op_q == NFCS_OP_READ) begin
      prev_q <= rdata_q;
      rdata_q <= bc_rdata;
      toggled_q <= (bc_rdata[NFCS_BIT_TOGGLE] != rdata_q[NFCS_BIT_TOGGLE]);
    end
  end

  // register read mux
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h00000000;
    end else if (clk_en_i && psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        NFCS_REG_CTRL: prdata_o <= {28'h0000000, op_q};
        NFCS_REG_ADDR: prdata_o <= {13'h0000, addr_q};
        NFCS_REG_WDATA: prdata_o <= {24'h000000, wdata_q};
        NFCS_REG_STATUS: prdata_o <= {22'h000000, rdata_q[NFCS_BIT_FAIL], toggled_q,
                                      prev_q[NFCS_BIT_TOGGLE], rdata_q[NFCS_BIT_TOGGLE],
                                      rdata_q[NFCS_BIT_WINDOW], rdata_q[NFCS_BIT_SECT],
                                      rdata_q[NFCS_BIT_POLL], 2'b00,
                                      (state_q != NFCS_IDLE)};
        NFCS_REG_RDATA: prdata_o <= {16'h0000, prev_q, rdata_q};
        default: prdata_o <= 32'h00000000;
      endcase
    end
  end

  nfcs_bus_cycle u_cycle (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .start_i(bc_start),
    .write_i(bc_write),
    .addr_i(bc_addr),
    .data_i(bc_data),
    .busy_o(bc_busy),
    .done_o(bc_done),
    .rdata_o(bc_rdata),
    .fl_addr_o(fl_addr_o),
    .fl_ce_n_o(fl_ce_n_o),
    .fl_we_n_o(fl_we_n_o),
    .fl_oe_n_o(fl_oe_n_o),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o),
    .fl_dq_i(fl_dq_i)
  );
endmodule : nfcs_top

//--- bench/nfcs_props.sv
`timescale 1ns/1ps
// pin protocol checks on the flash side
module nfcs_props (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [18:0] fl_addr_o,
  input wire logic fl_ce_n_o,
  input wire logic fl_we_n_o,
  input wire logic fl_oe_n_o,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_dq_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_write_sel: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
    else $error("write strobe without select");
  a_read_quiet: assert property (!fl_oe_n_o |-> fl_we_n_o && !fl_dq_oe_o)
    else $error("read while driving");
  a_write_drive: assert property (!fl_we_n_o |-> fl_dq_oe_o)
    else $error("write data not driven");
  a_addr_hold: assert property (!fl_ce_n_o && !$past(fl_ce_n_o) |-> $stable(fl_addr_o))
    else $error("address moved");
  a_data_hold: assert property (!fl_we_n_o && !$past(fl_we_n_o) |-> $stable(fl_dq_o))
    else $error("data moved");
  a_strobe_len: assert property ($fell(fl_ce_n_o) |-> !fl_ce_n_o [*3] ##1 fl_ce_n_o)
    else $error("strobe width wrong");
  a_idle_gap: assert property ($rose(fl_ce_n_o) |-> fl_ce_n_o [*2])
    else $error("no idle between cycles");
  a_reset_idle: assert property (disable iff (1'b0) !resetn_i |=> fl_ce_n_o && fl_we_n_o)
    else $error("strobes low after reset");
endmodule : nfcs_props
bind nfcs_top nfcs_props u_nfcs_props (.clock_i(clock_i), .resetn_i(resetn_i),
  .fl_addr_o(fl_addr_o), .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o),
  .fl_oe_n_o(fl_oe_n_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o));

//--- bench/nfcs_flash_model.sv
`timescale 1ns/1ps
// behavioural byte flash answering on its strobes
module nfcs_flash_model #(
  parameter int BUSY_NS = 8000,
  parameter logic [18:0] FAIL_A = 19'h01234,
  parameter logic [2:0] PROT = 3'h7,
  parameter logic [7:0] ID_CODE = 8'h3C // arbitrary value
) (
  input wire logic [18:0] addr_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o = 8'h00
);
  localparam logic [2:0] ARR = 3'h0, AUTO = 3'h1, QRY = 3'h2, BUSY = 3'h3, WIN = 3'h4;
  logic [7:0] mem [0:524287];
  logic [18:0] la;
  logic [7:0] ld, pd, sel;
  logic tog = 1'b0, er, fail = 1'b0;
  int step = 0;
  time end_t;
  logic [2:0] mode = ARR;
  wire wr_n = ce_n_i | we_n_i;
  wire rd_n = ce_n_i | oe_n_i;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // expiry starts erase, busy ends alone unless fail is set
  task automatic tick();
    if (mode == WIN && $time > end_t) begin
      for (int a = 0; a < 524288; a++) if (sel[a[18:16]]) mem[a] = 8'hFF;
      mode = BUSY;
      end_t = $time + 20000;
    end else if (mode == BUSY && !fail && $time > end_t) mode = ARR;
  endtask
  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    tick();
    // busy ignores all but failure reset
    if (mode == BUSY) begin
      if (fail && d == 8'hF0) {mode, fail} = {ARR, 1'b0};
    end else if (d == 8'hF0 || (mode == WIN && d != 8'h30 && d != 8'hB0)) begin
      mode = ARR;
      step = 0;
    end else if (mode == WIN) begin
      if (d == 8'h30) sel[a[18:16]] |= a[18:16] != PROT;
      end_t = $time + 50000;
    end else if (mode != ARR) begin
    end else if (step == 3) begin
      if (a[18:16] != PROT) mem[a] &= d;
      {pd, er, fail, mode, step} = {d, 1'b0, a == FAIL_A, BUSY, 32'd0};
      end_t = $time + (a[18:16] == PROT ? 1000 : BUSY_NS);
    end else if (step == 6 && d == 8'h10) begin
      for (int i = 0; i < 524288; i++) if (i[18:16] != PROT) mem[i] = 8'hFF;
      {er, mode, step} = {1'b1, BUSY, 32'd0};
      end_t = $time + 20000;
    end else if (step == 6 && d == 8'h30) begin
      sel = '0;
      sel[a[18:16]] = a[18:16] != PROT;
      {er, mode, step} = {1'b1, WIN, 32'd0};
      end_t = $time + 50000;
    end else if (step == 0 && a == 19'h000AA && d == 8'h98) mode = QRY;
    else if (step == 2 && a == 19'h00555 && d == 8'h90) {mode, step} = {AUTO, 32'd0};
    else if (step == 2 && a == 19'h00555 && d == 8'hA0) step = 3;
    else if (step == 2 && a == 19'h00555 && d == 8'h80) step = 4;
    else if (step % 4 == 0 && a == 19'h00555 && d == 8'hAA) step++;
    else if (step % 4 == 1 && a == 19'h002AA && d == 8'h55) step++;
    else step = 0;
  endtask
  // address on later fall, data on earlier rise
  always @(negedge wr_n) la = addr_i;
  always @(dq_i or wr_n) if (!wr_n) ld = dq_i;
  always @(posedge wr_n) if (oe_n_i && !$isunknown(la)) cmd(la, ld);
  // status reads, toggle flips each read
  always @(negedge rd_n) begin
    tick();
    tog = ~tog;
    case (mode)
      BUSY: dq_o = er ? {1'b0, tog, fail, 2'b01, tog, 2'b00} : {~pd[7], tog, fail, 5'h00};
      WIN: dq_o = {1'b0, tog, 3'h0, tog, 2'b00};
      AUTO: dq_o = addr_i[1] ? {7'h00, addr_i[18:16] == PROT} : ID_CODE;
      QRY: dq_o = 8'h00;
      default: dq_o = mem[addr_i];
    endcase
  end
  // released bus shows the inverse of the last value
  always @(posedge rd_n) dq_o = ~dq_o;
endmodule : nfcs_flash_model

//--- bench/nfcs_top_bench.sv
`timescale 1ns/1ps
// software on apb, controller, flash model
module nfcs_top_bench;
  import nfcs_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, st, v;
  logic pready_o, pslverr_o, ce_n, we_n, oe_n, dq_oe;
  logic [18:0] fa;
  logic [7:0] dq_c, dq_m, last_wd;
  wire [7:0] dq_w = dq_oe ? dq_c : dq_m;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  always #20 clock_i = ~clock_i;
  // last command byte seen by the flash at the strobe rise
  always @(posedge we_n) last_wd = dq_c;
  nfcs_top u_nfcs_top (.clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fl_addr_o(fa), .fl_ce_n_o(ce_n), .fl_we_n_o(we_n), .fl_oe_n_o(oe_n),
    .fl_dq_o(dq_c), .fl_dq_oe_o(dq_oe), .fl_dq_i(dq_w));
  nfcs_flash_model u_nfcs_flash_model (.addr_i(fa), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .dq_i(dq_w), .dq_o(dq_m));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one apb transfer, result left in v
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    v = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d);
    apb(1'b1, NFCS_REG_ADDR, 32'(a));
    apb(1'b1, NFCS_REG_WDATA, 32'(d));
    apb(1'b1, NFCS_REG_CTRL, 32'(c));
    for (int n = 0; n < 50; n++) begin
      apb(1'b0, NFCS_REG_STATUS, 32'h0);
      if (v[0] === 1'b0) break;
    end
  endtask : op
  task automatic rd(input logic [18:0] a);
    op(NFCS_OP_READ, a, 8'h00);
    apb(1'b0, NFCS_REG_STATUS, 32'h0);
    st = v;
    apb(1'b0, NFCS_REG_RDATA, 32'h0);
  endtask : rd
  // poll until the toggle bit stops
  task automatic settle(input logic [18:0] a);
    rd(a);
    for (int n = 0; n < 300; n++) begin
      rd(a);
      if (st[8] === 1'b0) break;
    end
  endtask : settle
  task automatic t_prog();
    op(NFCS_OP_PROGRAM, 19'h00100, 8'h5A);
    op(NFCS_OP_RESET, 19'h0, 8'h00);
    op(NFCS_OP_PROGRAM, 19'h00200, 8'h00);
    rd(19'h00100);
    chk("poll", 32'h1, 32'(st[3]));
    settle(19'h00100);
    chk("program", 32'h5A, 32'(v[7:0]));
    rd(19'h00200);
    chk("ignored", 32'hFF, 32'(v[7:0]));
    op(NFCS_OP_PROGRAM, 19'h00100, 8'h0F);
    settle(19'h00100);
    chk("zeros", 32'h0A, 32'(v[7:0]));
    op(NFCS_OP_PROGRAM, 19'h70010, 8'h00);
    settle(19'h70010);
    chk("protected", 32'hFF, 32'(v[7:0]));
    op(NFCS_OP_PROGRAM, 19'h01234, 8'h00);
    rd(19'h01234);
    chk("fail", 32'h1, 32'(st[9]));
    op(NFCS_OP_RESET, 19'h0, 8'h00);
    rd(19'h00100);
    chk("failreset", 32'h0A, 32'(v[7:0]));
  endtask : t_prog
  task automatic t_erase();
    op(NFCS_OP_CHIP_ERASE, 19'h0, 8'h00);
    rd(19'h00300);
    chk("epoll", 32'h0, 32'(st[3]));
    settle(19'h00100);
    chk("chip", 32'hFF, 32'(v[7:0]));
    for (int s = 1; s < 4; s++) begin
      op(NFCS_OP_PROGRAM, 19'(s << 16), 8'h00);
      settle(19'(s << 16));
    end
    op(NFCS_OP_SECTOR_ERASE, 19'h10000, 8'h00);
    op(NFCS_OP_ADD_SECTOR, 19'h20000, 8'h00);
    rd(19'h10000);
    chk("window", 32'h0, 32'(st[5]));
    for (int n = 0; n < 200 && st[5] !== 1'b1; n++) rd(19'h10000);
    chk("running", 32'h1, 32'(st[5]));
    settle(19'h10000);
    for (int s = 1; s < 4; s++) begin
      rd(19'(s << 16));
      chk("sector", s < 3 ? 32'hFF : 32'h0, 32'(v[7:0]));
    end
    op(NFCS_OP_SECTOR_ERASE, 19'h30000, 8'h00);
    op(NFCS_OP_RESET, 19'h0, 8'h00);
    repeat (1300) @(posedge clock_i);
    rd(19'h30000);
    chk("abort", 32'h0, 32'(v[7:0]));
  endtask : t_erase
  task automatic t_modes();
    op(NFCS_OP_AUTOSELECT, 19'h0, 8'h00);
    rd(19'h70002);
    chk("protect", 32'h1, 32'(v[7:0]));
    op(NFCS_OP_RESET, 19'h0, 8'h00);
    op(NFCS_OP_QUERY, 19'h0, 8'h00);
    rd(19'h00100);
    chk("query", 32'h0, 32'(v[7:0]));
    op(NFCS_OP_RESET, 19'h0, 8'h00);
    op(NFCS_OP_SUSPEND, 19'h0, 8'h00);
    chk("suspend", 32'(NFCS_CMD_SUSPEND), 32'(last_wd));
    op(NFCS_OP_RESUME, 19'h0, 8'h00);
    chk("resume", 32'(NFCS_CMD_RESUME), 32'(last_wd));
    rd(19'h00100);
    chk("array", 32'hFF, 32'(v[7:0]));
  endtask : t_modes
  task automatic final_report();
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // cut a hung run short
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", 32'h0, v);
    chk("slverr", 32'h0, 32'(pslverr_o));
    t_prog();
    t_erase();
    t_modes();
    final_report();
  end
endmodule : nfcs_top_bench
